//--- pkg/pmbus_cfg_pkg.sv
// Constants and types for the PMBus command interpreter
//
// Contract
// - 04h cut now, 44h soft off, 84h nominal on
// - 94h on margin low, A4h on margin high
// - Source 16h pin soft off, 17h pin immediate
// - Source 00h always on; 1Ah command only
// - E5h/E6h current fault actions default 80h
// - E7h average overcurrent limit, default DA80h
// - E8h average undercurrent limit, default DD80h
// - E9h option word, default 0400h
// - EAh read gives 32-byte captured block
// - F0h phase control byte, default 00h
// - Send byte F4h reloads factory defaults
// - F5h CB80h, F6h CA40h drive rail limits
// - F8h/F9h drive rail fault actions default 80h
// - FAh read-only access level, 01h after reset
// - Short float: 5-bit exponent, 11-bit mantissa
// - Unsigned fixed format: exponent always -13
// - Signed fixed format: same -13 exponent
// - Every command readable at any time; the code reads F4h back as FFh
package pmbus_cfg_pkg;
   // Command codes
   localparam logic [7:0] CMD_RUN = 8'h01;
   localparam logic [7:0] CMD_SRC = 8'h02;
   localparam logic [7:0] CMD_OC_ACT = 8'hE5;
   localparam logic [7:0] CMD_UC_ACT = 8'hE6;
   localparam logic [7:0] CMD_AVG_OC = 8'hE7;
   localparam logic [7:0] CMD_AVG_UC = 8'hE8;
   localparam logic [7:0] CMD_ADV = 8'hE9;
   localparam logic [7:0] CMD_SNAP = 8'hEA;
   localparam logic [7:0] CMD_SAVED = 8'hEB;
   localparam logic [7:0] CMD_PHASE = 8'hF0;
   localparam logic [7:0] CMD_RELOAD = 8'hF4;
   localparam logic [7:0] CMD_RAIL_HI = 8'hF5;
   localparam logic [7:0] CMD_RAIL_LO = 8'hF6;
   localparam logic [7:0] CMD_RAIL_RD = 8'hF7;
   localparam logic [7:0] CMD_RAIL_HI_ACT = 8'hF8;
   localparam logic [7:0] CMD_RAIL_LO_ACT = 8'hF9;
   localparam logic [7:0] CMD_LEVEL = 8'hFA;
   localparam logic [7:0] CMD_PRIV_PW = 8'hFB;
   localparam logic [7:0] CMD_PUB_PW = 8'hFC;
   localparam logic [7:0] CMD_UNPROT = 8'hFD;
   // Run-state values
   localparam logic [7:0] OP_OFF_NOW = 8'h04;
   localparam logic [7:0] OP_OFF_SOFT = 8'h44;
   localparam logic [7:0] OP_ON_NOM = 8'h84;
   localparam logic [7:0] OP_ON_LOW = 8'h94;
   localparam logic [7:0] OP_ON_HIGH = 8'hA4;
   localparam logic [7:0] OP_RESET = OP_OFF_NOW;
   // On/off source values
   localparam logic [7:0] SRC_ALWAYS = 8'h00;
   localparam logic [7:0] SRC_PIN_SOFT = 8'h16;
   localparam logic [7:0] SRC_PIN_NOW = 8'h17;
   localparam logic [7:0] SRC_CMD = 8'h1A;
   localparam logic [7:0] SRC_RESET = SRC_PIN_SOFT;
   // Fixed read values
   localparam logic [7:0] LEVEL_PUBLIC = 8'h01;
   localparam logic [15:0] SAVED_RESET = 16'hFFFF;
   localparam logic [7:0] SNAP_COUNT = 8'h20;
   localparam logic [7:0] PAIR_COUNT = 8'h02;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam int FIXED_EXP = -13;
   // Link byte framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] RX_SEND = 3'h1;
   localparam logic [2:0] RX_BYTE = 3'h2;
   localparam logic [2:0] RX_WORD = 3'h3;
   localparam logic [2:0] RX_BLOCK = 3'h4;
   localparam logic [2:0] RX_MAX = 3'h7;
   localparam logic [5:0] IDX_MAX = 6'h3F;

   // Short float word: value is mant times two to exp
   typedef struct packed {
      logic [4:0] exp;
      logic [10:0] mant;
   } linear_short_float_t;

   // Stored settings
   typedef struct packed {
      logic [7:0] oc_act;
      logic [7:0] uc_act;
      linear_short_float_t avg_oc;
      linear_short_float_t avg_uc;
      logic [15:0] adv_opts;
      logic [7:0] phase_ctl;
      linear_short_float_t rail_hi;
      linear_short_float_t rail_lo;
      logic [7:0] rail_hi_act;
      logic [7:0] rail_lo_act;
      logic [15:0] priv_pw;
      logic [15:0] pub_pw;
      logic [15:0] unprot;
   } cfg_t;

   // Factory defaults
   localparam cfg_t CFG_DEFAULT = '{
      oc_act: 8'h80, uc_act: 8'h80,
      avg_oc: 16'hDA80, avg_uc: 16'hDD80, adv_opts: 16'h0400,
      phase_ctl: 8'h00, rail_hi: 16'hCB80, rail_lo: 16'hCA40,
      rail_hi_act: 8'h80, rail_lo_act: 8'h80,
      priv_pw: 16'h0000, pub_pw: 16'h0000, unprot: 16'hFFFF};

   typedef enum logic [1:0] {MARGIN_NOM, MARGIN_LOW, MARGIN_HIGH} margin_t;

   // Power stage control
   typedef struct packed {
      logic run;
      logic imm_off;
      margin_t margin;
   } run_t;

   typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_MACK} link_state_t;
endpackage : pmbus_cfg_pkg

//--- verilog/pmbus_config_command_set.sv
// PMBus slave, command decoder and settings store
`timescale 1ns/1ns
module pmbus_config_command_set #(
   parameter logic [6:0] DEV_ADDR = 7'h20 // Bus address
) (
   input wire logic clk, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic scl_in, // Bus clock pin
   input wire logic sda_in, // Bus data pin level
   output logic sda_out, // Data pin drive level
   output logic sda_oe, // Data pin pulled low
   input wire logic enable_pin, // Enable pin, async
   input wire logic power_present, // Input power ok, async
   input wire logic [255:0] snapshot_in, // Captured values
   input wire logic [15:0] rail_reading_in, // Drive rail reading
   output pmbus_cfg_pkg::cfg_t cfg, // Stored settings
   output pmbus_cfg_pkg::run_t run_ctl, // Power stage control
   output logic factory_reload // Reload pulse
);
   logic scl_s1, scl_s2, scl_s3; // Clock synchroniser
   logic sda_s1, sda_s2, sda_s3; // Data synchroniser
   logic en_s1, en_s2; // Enable synchroniser
   logic pwr_s1, pwr_s2; // Power synchroniser
   pmbus_cfg_pkg::link_state_t state_q; // Link state
   logic [3:0] bit_q; // Bits in current byte
   logic [7:0] sr_q; // Receive shifter
   logic [7:0] tx_q; // Transmit shifter
   logic rd_q; // Read direction
   logic nack_q; // Host ack bit
   logic [2:0] rx_cnt_q; // Bytes after address
   logic wr_phase_q; // Write address seen
   logic [7:0] cmd_q; // Command code
   logic [7:0] wbuf_q [3]; // Write data bytes
   logic [5:0] ridx_q; // Read byte index
   logic [7:0] op_q; // Run-state command
   logic [7:0] src_q; // On/off source
   pmbus_cfg_pkg::cfg_t cfg_q; // Settings
   pmbus_cfg_pkg::run_t run_q, run_d; // Control outputs
   logic reload_q; // Reload pulse reg
   logic [7:0] rd_byte; // Next byte to send, from the read lookup

   // Two stages before use; third stage only for edges
   always_ff @(posedge clk)
   begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      en_s1 <= enable_pin;
      en_s2 <= en_s1;
      pwr_s1 <= power_present;
      pwr_s2 <= pwr_s1;
   end

   // Bus events
   wire scl_rise = scl_s2 & ~scl_s3;
   wire scl_fall = ~scl_s2 & scl_s3;
   wire start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire stop_ev = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   wire byte_done = bit_q == pmbus_cfg_pkg::BYTE_BITS;
   wire addr_hit = sr_q[7:1] == DEV_ADDR;

   // Commit decode at stop, by bytes received
   wire commit = stop_ev & wr_phase_q;
   wire wr_byte = commit & (rx_cnt_q == pmbus_cfg_pkg::RX_BYTE);
   wire wr_word = commit & (rx_cnt_q == pmbus_cfg_pkg::RX_WORD);
   wire wr_block = commit & (rx_cnt_q == pmbus_cfg_pkg::RX_BLOCK);
   wire reload = commit & (rx_cnt_q == pmbus_cfg_pkg::RX_SEND)
      & (cmd_q == pmbus_cfg_pkg::CMD_RELOAD);
   wire [15:0] word_in = {wbuf_q[1], wbuf_q[0]}; // Low byte first
   wire [15:0] block_in = {wbuf_q[2], wbuf_q[1]}; // After count byte

   // Only listed codes may be stored
   wire op_ok = wbuf_q[0] inside {pmbus_cfg_pkg::OP_OFF_NOW,
      pmbus_cfg_pkg::OP_OFF_SOFT, pmbus_cfg_pkg::OP_ON_NOM,
      pmbus_cfg_pkg::OP_ON_LOW, pmbus_cfg_pkg::OP_ON_HIGH};
   wire src_ok = wbuf_q[0] inside {pmbus_cfg_pkg::SRC_ALWAYS,
      pmbus_cfg_pkg::SRC_PIN_SOFT, pmbus_cfg_pkg::SRC_PIN_NOW,
      pmbus_cfg_pkg::SRC_CMD};

   // Link state machine; acts only on bus events
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= pmbus_cfg_pkg::ST_IDLE;
         bit_q <= '0;
         sr_q <= '0;
         tx_q <= pmbus_cfg_pkg::IDLE_BYTE;
         rd_q <= 1'b0;
         nack_q <= 1'b1;
         rx_cnt_q <= '0;
         wr_phase_q <= 1'b0;
         cmd_q <= '0;
         ridx_q <= '0;
         wbuf_q <= '{default: '0};
      end
      else if (start_ev)
      begin
         // Repeated start keeps the command for the read
         state_q <= pmbus_cfg_pkg::ST_ADDR;
         bit_q <= '0;
         rx_cnt_q <= '0;
         wr_phase_q <= 1'b0;
      end
      else if (stop_ev)
      begin
         state_q <= pmbus_cfg_pkg::ST_IDLE;
         wr_phase_q <= 1'b0;
      end
      else if (scl_rise)
      begin
         sr_q <= {sr_q[6:0], sda_s2};
         nack_q <= sda_s2;
         if (state_q inside {pmbus_cfg_pkg::ST_ADDR, pmbus_cfg_pkg::ST_WRITE,
            pmbus_cfg_pkg::ST_READ})
            bit_q <= bit_q + 4'h1;
      end
      else if (scl_fall)
      begin
         unique case (state_q)
            pmbus_cfg_pkg::ST_IDLE: ; // Not addressed
            pmbus_cfg_pkg::ST_ADDR:
               if (byte_done && addr_hit)
               begin
                  state_q <= pmbus_cfg_pkg::ST_ACK;
                  rd_q <= sr_q[0];
                  wr_phase_q <= ~sr_q[0];
                  ridx_q <= '0;
               end
               else if (byte_done)
                  state_q <= pmbus_cfg_pkg::ST_IDLE;
            pmbus_cfg_pkg::ST_WRITE:
               if (byte_done)
               begin
                  // First byte is the command, then data
                  if (rx_cnt_q == '0)
                     cmd_q <= sr_q;
                  else if (rx_cnt_q < pmbus_cfg_pkg::RX_BLOCK)
                     wbuf_q[rx_cnt_q[1:0] - 2'h1] <= sr_q;
                  if (rx_cnt_q != pmbus_cfg_pkg::RX_MAX)
                     rx_cnt_q <= rx_cnt_q + 3'h1;
                  state_q <= pmbus_cfg_pkg::ST_ACK;
               end
            pmbus_cfg_pkg::ST_ACK:
            begin
               bit_q <= '0;
               if (rd_q)
               begin
                  state_q <= pmbus_cfg_pkg::ST_READ;
                  tx_q <= rd_byte;
               end
               else
                  state_q <= pmbus_cfg_pkg::ST_WRITE;
            end
            pmbus_cfg_pkg::ST_READ:
               if (byte_done)
               begin
                  // Index moves now so the next byte is ready
                  state_q <= pmbus_cfg_pkg::ST_MACK;
                  if (ridx_q != pmbus_cfg_pkg::IDX_MAX)
                     ridx_q <= ridx_q + 6'h1;
               end
               else
                  tx_q <= {tx_q[6:0], 1'b1};
            pmbus_cfg_pkg::ST_MACK:
               if (nack_q)
                  state_q <= pmbus_cfg_pkg::ST_IDLE;
               else
               begin
                  state_q <= pmbus_cfg_pkg::ST_READ;
                  bit_q <= '0;
                  tx_q <= rd_byte;
               end
         endcase
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = (state_q == pmbus_cfg_pkg::ST_ACK)
      | ((state_q == pmbus_cfg_pkg::ST_READ) & ~tx_q[7]);

   // Read lookup; answers whatever the output state
   logic [15:0] reg_word; // Selected value
   logic is_byte, is_blk, known; // Value kind
   always_comb
   begin
      reg_word = {pmbus_cfg_pkg::IDLE_BYTE, pmbus_cfg_pkg::IDLE_BYTE};
      is_byte = 1'b0;
      is_blk = 1'b0;
      known = 1'b1;
      case (cmd_q)
         pmbus_cfg_pkg::CMD_RUN: {is_byte, reg_word} = {1'b1, 8'h00, op_q};
         pmbus_cfg_pkg::CMD_SRC: {is_byte, reg_word} = {1'b1, 8'h00, src_q};
         pmbus_cfg_pkg::CMD_OC_ACT: {is_byte, reg_word} = {1'b1, 8'h00, cfg_q.oc_act};
         pmbus_cfg_pkg::CMD_UC_ACT: {is_byte, reg_word} = {1'b1, 8'h00, cfg_q.uc_act};
         pmbus_cfg_pkg::CMD_PHASE: {is_byte, reg_word} = {1'b1, 8'h00, cfg_q.phase_ctl};
         pmbus_cfg_pkg::CMD_RAIL_HI_ACT:
            {is_byte, reg_word} = {1'b1, 8'h00, cfg_q.rail_hi_act};
         pmbus_cfg_pkg::CMD_RAIL_LO_ACT:
            {is_byte, reg_word} = {1'b1, 8'h00, cfg_q.rail_lo_act};
         pmbus_cfg_pkg::CMD_LEVEL:
            {is_byte, reg_word} = {1'b1, 8'h00, pmbus_cfg_pkg::LEVEL_PUBLIC};
         pmbus_cfg_pkg::CMD_AVG_OC: reg_word = cfg_q.avg_oc;
         pmbus_cfg_pkg::CMD_AVG_UC: reg_word = cfg_q.avg_uc;
         pmbus_cfg_pkg::CMD_ADV: reg_word = cfg_q.adv_opts;
         pmbus_cfg_pkg::CMD_RAIL_HI: reg_word = cfg_q.rail_hi;
         pmbus_cfg_pkg::CMD_RAIL_LO: reg_word = cfg_q.rail_lo;
         pmbus_cfg_pkg::CMD_RAIL_RD: reg_word = rail_reading_in;
         pmbus_cfg_pkg::CMD_SAVED: {is_blk, reg_word} = {1'b1, pmbus_cfg_pkg::SAVED_RESET};
         pmbus_cfg_pkg::CMD_PRIV_PW: {is_blk, reg_word} = {1'b1, cfg_q.priv_pw};
         pmbus_cfg_pkg::CMD_PUB_PW: {is_blk, reg_word} = {1'b1, cfg_q.pub_pw};
         pmbus_cfg_pkg::CMD_UNPROT: {is_blk, reg_word} = {1'b1, cfg_q.unprot};
         default: known = 1'b0;
      endcase
   end

   // Byte at the current read index
   wire [5:0] blk_idx = ridx_q - 6'h1;
   wire [7:0] snap_byte = snapshot_in[{blk_idx[4:0], 3'h0} +: 8];
   wire [7:0] lo_b = reg_word[7:0];
   wire [7:0] hi_b = reg_word[15:8];
   wire [7:0] snap_rd = (ridx_q == 6'h0) ? pmbus_cfg_pkg::SNAP_COUNT
      : (ridx_q <= 6'h20) ? snap_byte : pmbus_cfg_pkg::IDLE_BYTE;
   wire [7:0] blk_rd = (ridx_q == 6'h0) ? pmbus_cfg_pkg::PAIR_COUNT
      : (ridx_q == 6'h1) ? lo_b : (ridx_q == 6'h2) ? hi_b : pmbus_cfg_pkg::IDLE_BYTE;
   wire [7:0] word_rd = (ridx_q == 6'h0) ? lo_b
      : (ridx_q == 6'h1 && !is_byte) ? hi_b : pmbus_cfg_pkg::IDLE_BYTE;
   assign rd_byte = (cmd_q == pmbus_cfg_pkg::CMD_SNAP) ? snap_rd
      : is_blk ? blk_rd : known ? word_rd : pmbus_cfg_pkg::IDLE_BYTE;

   // Settings store; reload and reset give the same defaults
   always_ff @(posedge clk)
   begin
      if (reset || reload)
      begin
         cfg_q <= pmbus_cfg_pkg::CFG_DEFAULT;
         op_q <= pmbus_cfg_pkg::OP_RESET;
         src_q <= pmbus_cfg_pkg::SRC_RESET;
      end
      else if (wr_byte)
      begin
         case (cmd_q)
            pmbus_cfg_pkg::CMD_RUN: if (op_ok) op_q <= wbuf_q[0];
            pmbus_cfg_pkg::CMD_SRC: if (src_ok) src_q <= wbuf_q[0];
            pmbus_cfg_pkg::CMD_OC_ACT: cfg_q.oc_act <= wbuf_q[0];
            pmbus_cfg_pkg::CMD_UC_ACT: cfg_q.uc_act <= wbuf_q[0];
            pmbus_cfg_pkg::CMD_PHASE: cfg_q.phase_ctl <= wbuf_q[0];
            pmbus_cfg_pkg::CMD_RAIL_HI_ACT: cfg_q.rail_hi_act <= wbuf_q[0];
            pmbus_cfg_pkg::CMD_RAIL_LO_ACT: cfg_q.rail_lo_act <= wbuf_q[0];
            default: ; // Read-only or unknown
         endcase
      end
      else if (wr_word)
      begin
         case (cmd_q)
            pmbus_cfg_pkg::CMD_AVG_OC: cfg_q.avg_oc <= word_in;
            pmbus_cfg_pkg::CMD_AVG_UC: cfg_q.avg_uc <= word_in;
            pmbus_cfg_pkg::CMD_ADV: cfg_q.adv_opts <= word_in;
            pmbus_cfg_pkg::CMD_RAIL_HI: cfg_q.rail_hi <= word_in;
            pmbus_cfg_pkg::CMD_RAIL_LO: cfg_q.rail_lo <= word_in;
            default: ;
         endcase
      end
      else if (wr_block)
      begin
         case (cmd_q)
            pmbus_cfg_pkg::CMD_PRIV_PW: cfg_q.priv_pw <= block_in;
            pmbus_cfg_pkg::CMD_PUB_PW: cfg_q.pub_pw <= block_in;
            pmbus_cfg_pkg::CMD_UNPROT: cfg_q.unprot <= block_in;
            default: ;
         endcase
      end
   end

   // Output on/off from the selected source
   wire src_pin = (src_q == pmbus_cfg_pkg::SRC_PIN_SOFT)
      | (src_q == pmbus_cfg_pkg::SRC_PIN_NOW);
   wire op_on = op_q inside {pmbus_cfg_pkg::OP_ON_NOM,
      pmbus_cfg_pkg::OP_ON_LOW, pmbus_cfg_pkg::OP_ON_HIGH};
   wire run_on = (src_q == pmbus_cfg_pkg::SRC_ALWAYS) ? pwr_s2
      : src_pin ? en_s2 : op_on;
   wire cut_now = (src_q == pmbus_cfg_pkg::SRC_CMD)
      ? (op_q == pmbus_cfg_pkg::OP_OFF_NOW)
      : (src_q == pmbus_cfg_pkg::SRC_PIN_NOW);
   pmbus_cfg_pkg::margin_t margin_sel; // Margin from the run-state byte
   assign margin_sel = (op_q == pmbus_cfg_pkg::OP_ON_LOW) ? pmbus_cfg_pkg::MARGIN_LOW
      : (op_q == pmbus_cfg_pkg::OP_ON_HIGH) ? pmbus_cfg_pkg::MARGIN_HIGH
      : pmbus_cfg_pkg::MARGIN_NOM;
   // One driver for the whole control word
   assign run_d = '{run: run_on, imm_off: cut_now, margin: margin_sel};

   // Registered control outputs
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         run_q <= '{run: 1'b0, imm_off: 1'b0, margin: pmbus_cfg_pkg::MARGIN_NOM};
         reload_q <= 1'b0;
      end
      else
      begin
         run_q <= run_d;
         reload_q <= reload;
      end
   end

   assign cfg = cfg_q;
   assign run_ctl = run_q;
   assign factory_reload = reload_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_cmd_on_nominal;
      (src_q == pmbus_cfg_pkg::SRC_CMD) && (op_q == pmbus_cfg_pkg::OP_ON_NOM)
         ##1 (src_q == pmbus_cfg_pkg::SRC_CMD)
         |-> run_ctl.run && run_ctl.margin == pmbus_cfg_pkg::MARGIN_NOM;
   endproperty
   a_cmd_on_nominal: assert property (p_cmd_on_nominal)
      else $error("nominal turn-on not applied");

   property p_cmd_off_now;
      (src_q == pmbus_cfg_pkg::SRC_CMD) && (op_q == pmbus_cfg_pkg::OP_OFF_NOW)
         |=> !run_ctl.run && run_ctl.imm_off;
   endproperty
   a_cmd_off_now: assert property (p_cmd_off_now)
      else $error("immediate off not applied");

   property p_margin_high;
      op_q == pmbus_cfg_pkg::OP_ON_HIGH |=> run_ctl.margin == pmbus_cfg_pkg::MARGIN_HIGH;
   endproperty
   a_margin_high: assert property (p_margin_high)
      else $error("margin high not selected");

   property p_pin_soft;
      (src_q == pmbus_cfg_pkg::SRC_PIN_SOFT)
         |=> run_ctl.run == $past(en_s2) && !run_ctl.imm_off;
   endproperty
   a_pin_soft: assert property (p_pin_soft)
      else $error("enable pin control wrong");

   property p_always_on;
      (src_q == pmbus_cfg_pkg::SRC_ALWAYS) |=> run_ctl.run == $past(pwr_s2);
   endproperty
   a_always_on: assert property (p_always_on)
      else $error("power-present start wrong");

   property p_reload_defaults;
      reload |=> cfg == pmbus_cfg_pkg::CFG_DEFAULT && factory_reload
         ##1 !factory_reload;
   endproperty
   a_reload_defaults: assert property (p_reload_defaults)
      else $error("factory reload incomplete");

   property p_snap_count;
      (cmd_q == pmbus_cfg_pkg::CMD_SNAP) && (ridx_q == 6'h0)
         |-> rd_byte == pmbus_cfg_pkg::SNAP_COUNT;
   endproperty
   a_snap_count: assert property (p_snap_count)
      else $error("snapshot count not 32");

   property p_level_public;
      (cmd_q == pmbus_cfg_pkg::CMD_LEVEL) && (ridx_q == 6'h0)
         |-> rd_byte == pmbus_cfg_pkg::LEVEL_PUBLIC;
   endproperty
   a_level_public: assert property (p_level_public)
      else $error("access level not public");

   property p_bad_run_kept;
      wr_byte && (cmd_q == pmbus_cfg_pkg::CMD_RUN) && !op_ok |=> op_q == $past(op_q);
   endproperty
   a_bad_run_kept: assert property (p_bad_run_kept)
      else $error("unlisted run value stored");

   property p_word_store;
      wr_word && (cmd_q == pmbus_cfg_pkg::CMD_AVG_OC)
         |=> cfg.avg_oc == $past(word_in) ##1 $stable(cfg.avg_oc) || reload;
   endproperty
   a_word_store: assert property (p_word_store)
      else $error("limit word not stored");

   c_word_write: cover property (wr_word);
   c_reload: cover property (reload);
   c_snap_tail: cover property ((cmd_q == pmbus_cfg_pkg::CMD_SNAP) && ridx_q == 6'h20);
   c_read_on: cover property (run_ctl.run && state_q == pmbus_cfg_pkg::ST_READ);
endmodule : pmbus_config_command_set

//--- tb/pmbus_host_model.sv
// Bus master model: drives SCL, pulls SDA, resolves the wire
`timescale 1ns/1ns
module pmbus_host_model (
   input wire logic clk, // System clock
   input wire logic dev_oe, // Device pulls SDA low
   output logic scl, // Bus clock, high when idle
   output logic sda // Resolved SDA level
);
   logic low_q = 1'b0; // Host pulls SDA low
   // Pull-up: a released wire reads high, never the last value
   assign sda = !(low_q || dev_oe);
   // Bus clock stands still high outside frames
   initial scl = 1'b1;
   // Quarter of an 800 ns bus period
   task automatic q;
      repeat (2) @(posedge clk);
   endtask : q
   // Start or repeated start; SDA falls while SCL high
   task automatic start;
      low_q <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      low_q <= 1'b1;
      q();
      scl <= 1'b0;
      q();
   endtask : start
   // One bit; data changes only while SCL is low
   task automatic bit_io(input logic b, output logic r);
      low_q <= !b;
      q();
      scl <= 1'b1;
      q();
      r = sda;
      q();
      scl <= 1'b0;
      q();
   endtask : bit_io
   // Eight bits MSB first, then the ninth bit
   task automatic byte_io(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
      output logic r9);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(b9, r9);
   endtask : byte_io
   // Stop; SDA rises while SCL high
   task automatic stop;
      low_q <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      low_q <= 1'b0;
      q();
   endtask : stop
endmodule : pmbus_host_model

//--- tb/pmbus_config_command_set_tb_top.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ns
module pmbus_config_command_set_tb_top;
   logic clk = 1'b0; // System clock
   logic reset = 1'b1; // Synchronous reset
   logic scl; // Bus clock
   logic sda; // Resolved data wire
   logic sda_oe; // Device pulls SDA low
   logic sda_out; // Device drive level, must stay low
   logic enable_pin = 1'b0; // Enable pin
   logic power_present = 1'b0; // Input power ok
   logic [255:0] snap = '0; // Captured values
   logic [15:0] rail = '0; // Drive rail reading
   pmbus_cfg_pkg::cfg_t cfg; // Stored settings
   pmbus_cfg_pkg::run_t run_ctl; // Power stage control
   logic reload; // Reload pulse
   logic [7:0] rb [0:33]; // Bytes of the last read
   int exp_reg [int]; // Expected register contents
   int dflt [int]; // Factory values
   int errors = 0; // Mismatches
   int checks = 0; // Comparisons
   int pulses = 0; // Reload pulses seen
   logic [31:0] seed = 32'h00000040; // Xorshift state
   // Run-state byte and expected run, imm_off, margin
   logic [11:0] op [6] = '{12'h044, 12'h440, 12'h848, 12'h949, 12'hA4A, 12'h55A};
   // Source, pin, power, run, imm_off (F: not checked)
   logic [23:0] src [7] = '{24'h16101F, 24'h160000, 24'h17101F, 24'h170001,
      24'h00011F, 24'h00000F, 24'h33011F};
   // Clock, 100 ns period
   initial
   begin
      forever #50 clk = !clk;
   end
   pmbus_config_command_set i_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
      .power_present(power_present),
      .snapshot_in(snap), .rail_reading_in(rail), .cfg(cfg), .run_ctl(run_ctl),
      .factory_reload(reload));
   pmbus_host_model i_host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
   // Count reload pulses
   always @(posedge clk)
   begin
      if (reload === 1'b1) pulses++;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Short float to milli-units: mantissa times two to the exponent
   function automatic int l11_milli(input logic [15:0] w);
      int m;
      int e;
      m = $signed(w[10:0]);
      e = $signed(w[15:11]);
      return (e < 0) ? (m * 1000) >>> -e : (m * 1000) <<< e;
   endfunction : l11_milli
   task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string w);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %0t %s got %0h want %0h", $time, w, got, exp);
      end
   endtask : chk
   // Write n data bytes, low first; model follows settings
   task automatic wr(input logic [7:0] cmd, input int n, input logic [23:0] d);
      logic [7:0] x;
      logic a;
      i_host.start();
      i_host.byte_io(8'h40, 1'b1, x, a);
      i_host.byte_io(cmd, 1'b1, x, a);
      for (int i = 0; i < n; i++) i_host.byte_io(d[8*i+:8], 1'b1, x, a);
      i_host.stop();
      chk(a, 1'b0, "ack");
      if (exp_reg.exists(cmd)) exp_reg[cmd] = (n == 2) ? d[15:0] : d[7:0];
   endtask : wr
   // Read n bytes; host NACKs the last
   task automatic rd(input logic [7:0] cmd, input int n);
      logic a;
      i_host.start();
      i_host.byte_io(8'h40, 1'b1, rb[0], a);
      i_host.byte_io(cmd, 1'b1, rb[0], a);
      i_host.start();
      i_host.byte_io(8'h41, 1'b1, rb[0], a);
      for (int i = 0; i < n; i++) i_host.byte_io(8'hFF, i == n - 1, rb[i], a);
      i_host.stop();
   endtask : rd
   task automatic end_of_test;
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial
   begin
      logic nak; // Ninth bit after a foreign address
      dflt = '{8'hE5: 16'h80, 8'hE6: 16'h80, 8'hE7: 16'hDA80, 8'hE8: 16'hDD80,
         8'hE9: 16'h0400, 8'hF0: 16'h00, 8'hF5: 16'hCB80, 8'hF6: 16'hCA40,
         8'hF8: 16'h80, 8'hF9: 16'h80};
      exp_reg = dflt;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      chk(cfg, pmbus_cfg_pkg::CFG_DEFAULT, "cfg");
      chk(sda_out, 1'b0, "drive level");
      chk(l11_milli(cfg.avg_oc), 20000, "oc amps");
      chk(l11_milli(cfg.avg_uc), -20000, "uc amps");
      chk(l11_milli(cfg.rail_hi), 7000, "rail high");
      chk(l11_milli(cfg.rail_lo), 4500, "rail low");
      // Defaults, random writes, then factory reload
      for (int p = 0; p < 3; p++)
      begin
         if (p == 2)
         begin
            pulses = 0;
            wr(8'hF4, 0, 16'h0000);
            repeat (8) @(posedge clk);
            chk(pulses, 1, "pulse");
            chk(cfg, pmbus_cfg_pkg::CFG_DEFAULT, "reload");
            exp_reg = dflt;
         end
         foreach (exp_reg[c])
         begin
            int n;
            n = (c inside {8'hE7, 8'hE8, 8'hE9, 8'hF5, 8'hF6}) ? 2 : 1;
            if (p == 1) wr(8'(c), n, 16'(rnd()));
            rd(8'(c), n);
            chk({rb[1] & {8{n == 2}}, rb[0]}, exp_reg[c], "reg");
         end
      end
      // Read-only level ignores writes; unknown code reads idle
      wr(8'hFA, 1, 16'h0000);
      rd(8'hFA, 1);
      chk(rb[0], 8'h01, "level");
      rd(8'hC7, 1);
      chk(rb[0], 8'hFF, "unknown");
      // Block settings: count byte, then low and high
      for (int i = 0; i < 3; i++)
      begin
         logic [15:0] v;
         v = 16'(rnd());
         wr(8'hFB + 8'(i), 3, {v, 8'h02});
         rd(8'hFB + 8'(i), 3);
         chk({rb[2], rb[1], rb[0]}, {v, 8'h02}, "block");
      end
      rd(8'hEB, 3);
      chk({rb[2], rb[1], rb[0]}, 24'hFFFF02, "saved");
      // Foreign address gets no acknowledge
      i_host.start();
      i_host.byte_io(8'h42, 1'b1, rb[0], nak);
      i_host.stop();
      chk(nak, 1'b1, "foreign address");
      // Command-only source, every run-state code, one bad code
      wr(8'h02, 1, 16'h001A);
      foreach (op[i])
      begin
         wr(8'h01, 1, {8'h00, op[i][11:4]});
         repeat (4) @(posedge clk);
         chk(run_ctl, op[i][3:0], "run state");
      end
      // Reads while the output is on
      for (int i = 0; i < 8; i++) snap[32*i+:32] <= rnd();
      rail <= 16'(rnd());
      @(posedge clk);
      rd(8'hEA, 33);
      chk(rb[0], 8'h20, "count");
      for (int i = 0; i < 32; i++) chk(rb[i+1], snap[8*i+:8], "snap");
      rd(8'hF7, 2);
      chk({rb[1], rb[0]}, rail, "rail");
      // Sources against pin and power, run-state left off
      wr(8'h01, 1, 16'h0004);
      foreach (src[i])
      begin
         wr(8'h02, 1, {8'h00, src[i][23:16]});
         enable_pin <= src[i][12];
         power_present <= src[i][8];
         repeat (8) @(posedge clk);
         chk(run_ctl.run, src[i][4], "run");
         if (src[i][3:0] != 4'hF) chk(run_ctl.imm_off, src[i][0], "imm");
      end
      end_of_test();
   end
   // Watchdog
   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      end_of_test();
   end
endmodule : pmbus_config_command_set_tb_top
